// *** afe_regmap_pkg.sv ***
// Package with register map constants and carrier types for the front-end register bank.
package afe_regmap_pkg;
   localparam logic [6:0] ADDR_NULL_LOW = 7'h00;
   localparam logic [6:0] ADDR_STATUS = 7'h01;
   localparam logic [6:0] ADDR_CAL_CFG = 7'h12;
   localparam logic [6:0] ADDR_MUX_CFG = 7'h14;
   localparam logic [6:0] ADDR_RATE_CFG = 7'h15;
   localparam logic [6:0] ADDR_BEAT_CFG_A = 7'h1d;
   localparam logic [6:0] ADDR_BEAT_CFG_B = 7'h1e;
   localparam logic [6:0] ADDR_QUEUE_BURST = 7'h20;
   localparam logic [6:0] ADDR_QUEUE_SINGLE = 7'h21;
   localparam logic [6:0] ADDR_BEAT_INTERVAL = 7'h25;
   localparam logic [6:0] ADDR_NULL_HIGH = 7'h7f;
   localparam int WORD_W = 24;
   localparam int FRAME_BITS = 32;
   localparam int ADDR_BITS = 7;
   localparam logic [5:0] CLEAR_EDGE = 6'h20;
   localparam logic [5:0] DATA_START = 6'h08;
   localparam int BIT_QUEUE_THR = 23;
   localparam int BIT_QUEUE_OVF = 22;
   localparam int BIT_FAST_REC = 21;
   localparam int BIT_LEAD_OFF = 20;
   localparam int BIT_LEADS_ON = 11;
   localparam int BIT_BEAT = 10;
   localparam int BIT_SAMPLE = 9;
   localparam int BIT_CLK_UNLOCK = 8;
   localparam logic [23:0] CFG_RESET = 24'h00_0000;
   localparam logic [23:0] CAL_CFG_MASK = 24'h70_7fff;
   localparam logic [23:0] MUX_CFG_MASK = 24'hbf_0000;
   localparam logic [23:0] RATE_CFG_MASK = 24'hc3_7000;
   localparam logic [23:0] BEAT_A_MASK = 24'hff_bf00;
   localparam logic [23:0] BEAT_B_MASK = 24'h3f_3700;
   localparam int LEAD_OFF_TIME_MS = 115;
   localparam int CLK_HZ = 50_000_000;
   localparam int LEAD_OFF_CYCLES = (LEAD_OFF_TIME_MS * (CLK_HZ / 1000)) + 1;
   typedef struct packed {
      logic queue_threshold_flag;
      logic queue_overflow_flag;
      logic fast_recovery_flag;
      logic leads_on_flag;
      logic beat_event_flag;
      logic sample_pulse_flag;
      logic clock_unlocked_flag;
   } event_in_s;
   typedef struct packed {
      logic pos_electrode_high_flag;
      logic pos_electrode_low_flag;
      logic neg_electrode_high_flag;
      logic neg_electrode_low_flag;
   } electrode_s;
endpackage : afe_regmap_pkg

// *** bit_sync.sv ***
// Two flip-flop synchroniser for a bundle of level signals.
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : bit_sync

// *** afe_status_regmap.sv ***
// Serial register bank with status flags, configuration and readback locations.
//
// Function
// - Addresses 0x00 and 0x7F are null registers with no internal effect.
// - Reads of a null register drive serial output zero for the whole frame.
// - Writes to a null register are discarded.
// - Status register at 0x01 is read-only, 24 bits of device conditions.
// - Upper two status bytes show raw terms regardless of interrupt enables.
// - Every status term is active high.
// - Low status byte carries the four electrode detail flags.
// - Bits: 23,22,21,20 queue/ovf/fast/leadoff; 11..8 on/beat/sample/pll; 3..0 detail.
// - Burst queue readback at 0x20 returns records continuously in one read.
// - Single queue readback at 0x21 returns one record per read.
// - Latest beat interval is readable at 0x25.
// - Latched conditions hold until a status read clears them at edge 32.
// - Overflow flag holds until a queue reset or resync command.
// - Lead-off asserts only after the condition persists beyond 115 ms.
// - Electrode detail flags set in the same cycle as lead-off.
`timescale 1ns/1ps
module afe_status_regmap #(
   parameter int LEAD_OFF_CNT = afe_regmap_pkg::LEAD_OFF_CYCLES
) (
   // System clock and reset.
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // Serial link from the host.
   input wire logic sclk_in,
   input wire logic csn_in,
   input wire logic sdi_in,
   output logic sdo_out,
   // Device events and readback sources.
   input wire afe_regmap_pkg::event_in_s events_in,
   input wire afe_regmap_pkg::electrode_s electrode_in,
   input wire logic lead_off_cond_in,
   input wire logic queue_reset_in,
   input wire logic resync_in,
   input wire logic [afe_regmap_pkg::WORD_W-1:0] queue_record_in,
   input wire logic [afe_regmap_pkg::WORD_W-1:0] beat_interval_in,
   // Queue pop request and configuration view.
   output logic queue_pop_out,
   output logic [afe_regmap_pkg::WORD_W-1:0] beat_cfg_a_out
);
   localparam int W = afe_regmap_pkg::WORD_W;

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: shift frame, address and data phases on the serial clock.
   logic [5:0] cnt_q, cnt_d;
   logic [6:0] addr_q, addr_d;
   logic rd_q, rd_d;
   logic [W-1:0] shreg_q, shreg_d;
   logic [W-1:0] wdat_q, wdat_d;
   logic sdo_q, sdo_d;
   logic clr_tog_q, clr_tog_d;
   logic pop_tog_q, pop_tog_d;
   logic wr_tog_q, wr_tog_d;
   logic [6:0] wr_addr_q, wr_addr_d;
   logic [W-1:0] rd_word;
   logic [W-1:0] status_word;
   logic [W-1:0] cal_cfg_q, mux_cfg_q, rate_cfg_q, beat_a_q, beat_b_q;
   logic [W-1:0] cfg_d [5];

   always_comb begin
      case (addr_d)
         afe_regmap_pkg::ADDR_STATUS: rd_word = status_word;
         afe_regmap_pkg::ADDR_CAL_CFG: rd_word = cal_cfg_q;
         afe_regmap_pkg::ADDR_MUX_CFG: rd_word = mux_cfg_q;
         afe_regmap_pkg::ADDR_RATE_CFG: rd_word = rate_cfg_q;
         afe_regmap_pkg::ADDR_BEAT_CFG_A: rd_word = beat_a_q;
         afe_regmap_pkg::ADDR_BEAT_CFG_B: rd_word = beat_b_q;
         afe_regmap_pkg::ADDR_QUEUE_BURST: rd_word = queue_record_in;
         afe_regmap_pkg::ADDR_QUEUE_SINGLE: rd_word = queue_record_in;
         afe_regmap_pkg::ADDR_BEAT_INTERVAL: rd_word = beat_interval_in;
         default: rd_word = '0;
      endcase
   end

   always_comb begin
      cnt_d = cnt_q + 6'h01;
      addr_d = addr_q;
      rd_d = rd_q;
      shreg_d = {shreg_q[W-2:0], 1'b0};
      wdat_d = {wdat_q[W-2:0], sdi_in};
      sdo_d = sdo_q;
      clr_tog_d = clr_tog_q;
      pop_tog_d = pop_tog_q;
      wr_tog_d = wr_tog_q;
      wr_addr_d = wr_addr_q;
      if (cnt_q < 6'(afe_regmap_pkg::ADDR_BITS)) begin
         addr_d = {addr_q[5:0], sdi_in};
      end else if (cnt_q == 6'(afe_regmap_pkg::ADDR_BITS)) begin
         rd_d = sdi_in;
         if (sdi_in) begin
            shreg_d = rd_word;
         end
      end
      if (rd_q && cnt_q >= afe_regmap_pkg::DATA_START) begin
         sdo_d = shreg_q[W-1];
      end else begin
         sdo_d = 1'b0;
      end
      // Burst reads reload the next record after each full word.
      if (rd_q && addr_q == afe_regmap_pkg::ADDR_QUEUE_BURST
          && cnt_q == afe_regmap_pkg::CLEAR_EDGE - 6'h01) begin
         pop_tog_d = ~pop_tog_q;
         cnt_d = afe_regmap_pkg::DATA_START;
         shreg_d = queue_record_in;
      end
      if (cnt_q == afe_regmap_pkg::CLEAR_EDGE - 6'h01 && rd_q) begin
         if (addr_q == afe_regmap_pkg::ADDR_STATUS) begin
            clr_tog_d = ~clr_tog_q;
         end
         if (addr_q == afe_regmap_pkg::ADDR_QUEUE_SINGLE) begin
            pop_tog_d = ~pop_tog_q;
         end
      end
      if (cnt_q == afe_regmap_pkg::CLEAR_EDGE - 6'h01 && !rd_q) begin
         wr_tog_d = ~wr_tog_q;
         wr_addr_d = addr_q;
      end
   end

   always_ff @(posedge sclk_in or posedge csn_in) begin
      if (csn_in) begin
         cnt_q <= '0;
         addr_q <= '0;
         rd_q <= 1'b0;
         shreg_q <= '0;
         wdat_q <= '0;
         sdo_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         rd_q <= rd_d;
         shreg_q <= shreg_d;
         wdat_q <= wdat_d;
         sdo_q <= sdo_d;
      end
   end

   always_ff @(posedge sclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         clr_tog_q <= 1'b0;
         pop_tog_q <= 1'b0;
         wr_tog_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         clr_tog_q <= clr_tog_d;
         pop_tog_q <= pop_tog_d;
         wr_tog_q <= wr_tog_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers: written on the link clock, stable between frames.
   always_comb begin
      cfg_d[0] = cal_cfg_q;
      cfg_d[1] = mux_cfg_q;
      cfg_d[2] = rate_cfg_q;
      cfg_d[3] = beat_a_q;
      cfg_d[4] = beat_b_q;
      if (cnt_q == afe_regmap_pkg::CLEAR_EDGE - 6'h01 && !rd_q) begin
         case (addr_q)
            afe_regmap_pkg::ADDR_CAL_CFG: cfg_d[0] = wdat_d & afe_regmap_pkg::CAL_CFG_MASK;
            afe_regmap_pkg::ADDR_MUX_CFG: cfg_d[1] = wdat_d & afe_regmap_pkg::MUX_CFG_MASK;
            afe_regmap_pkg::ADDR_RATE_CFG: cfg_d[2] = wdat_d & afe_regmap_pkg::RATE_CFG_MASK;
            afe_regmap_pkg::ADDR_BEAT_CFG_A: cfg_d[3] = wdat_d & afe_regmap_pkg::BEAT_A_MASK;
            afe_regmap_pkg::ADDR_BEAT_CFG_B: cfg_d[4] = wdat_d & afe_regmap_pkg::BEAT_B_MASK;
            default: cfg_d[0] = cal_cfg_q;
         endcase
      end
   end

   always_ff @(posedge sclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cal_cfg_q <= afe_regmap_pkg::CFG_RESET;
         mux_cfg_q <= afe_regmap_pkg::CFG_RESET;
         rate_cfg_q <= afe_regmap_pkg::CFG_RESET;
         beat_a_q <= afe_regmap_pkg::CFG_RESET;
         beat_b_q <= afe_regmap_pkg::CFG_RESET;
      end else begin
         cal_cfg_q <= cfg_d[0];
         mux_cfg_q <= cfg_d[1];
         rate_cfg_q <= cfg_d[2];
         beat_a_q <= cfg_d[3];
         beat_b_q <= cfg_d[4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // System domain: synchronise inputs and toggles, keep the latched flags.
   logic [2:0] tog_s;
   logic [2:0] tog_prev_q;
   logic [11:0] ev_s;
   logic [8:0] flags_q, flags_d;
   logic [3:0] detail_q, detail_d;
   logic [31:0] lo_cnt_q, lo_cnt_d;
   logic pop_q, pop_d;
   logic [W-1:0] beat_cfg_q, beat_cfg_d;
   logic clr_pulse, pop_pulse, lo_qual;

   bit_sync #(.WIDTH(3)) u_tog_sync (
      .clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .async_in({clr_tog_q, pop_tog_q, wr_tog_q}),
      .sync_out(tog_s)
   );

   bit_sync #(.WIDTH(12)) u_ev_sync (
      .clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .async_in({events_in, electrode_in, lead_off_cond_in}),
      .sync_out(ev_s)
   );

   assign clr_pulse = tog_s[2] ^ tog_prev_q[2];
   assign pop_pulse = tog_s[1] ^ tog_prev_q[1];
   assign lo_qual = (lo_cnt_q >= 32'(LEAD_OFF_CNT));

   // Flag order: thr, ovf, fast, leadoff, on, beat, sample, pll, unused.
   always_comb begin
      flags_d = flags_q;
      detail_d = detail_q;
      lo_cnt_d = ev_s[0] ? (lo_qual ? lo_cnt_q : lo_cnt_q + 32'h0000_0001) : '0;
      pop_d = pop_pulse;
      beat_cfg_d = (tog_s[0] ^ tog_prev_q[0]) ? beat_a_q : beat_cfg_q;
      if (clr_pulse) begin
         flags_d = '0;
         // A status read never clears the overflow flag.
         flags_d[7] = flags_q[7];
         detail_d = '0;
      end
      flags_d[8] = ev_s[11];
      if (ev_s[10]) flags_d[7] = 1'b1;
      if (queue_reset_in || resync_in) flags_d[7] = 1'b0;
      if (ev_s[10]) flags_d[7] = 1'b1;
      if (ev_s[9]) flags_d[6] = 1'b1;
      if (lo_qual) begin
         flags_d[5] = 1'b1;
         detail_d = detail_d | ev_s[4:1];
      end
      if (ev_s[8]) flags_d[4] = 1'b1;
      if (ev_s[7]) flags_d[3] = 1'b1;
      if (ev_s[6]) flags_d[2] = 1'b1;
      if (ev_s[5]) flags_d[1] = 1'b1;
      flags_d[0] = 1'b0;
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tog_prev_q <= '0;
         flags_q <= '0;
         detail_q <= '0;
         lo_cnt_q <= '0;
         pop_q <= 1'b0;
         beat_cfg_q <= afe_regmap_pkg::CFG_RESET;
      end else begin
         tog_prev_q <= tog_s;
         flags_q <= flags_d;
         detail_q <= detail_d;
         lo_cnt_q <= lo_cnt_d;
         pop_q <= pop_d;
         beat_cfg_q <= beat_cfg_d;
      end
   end

   // Status word, active high, unused bits zero.
   always_comb begin
      status_word = '0;
      status_word[afe_regmap_pkg::BIT_QUEUE_THR] = flags_q[8];
      status_word[afe_regmap_pkg::BIT_QUEUE_OVF] = flags_q[7];
      status_word[afe_regmap_pkg::BIT_FAST_REC] = flags_q[6];
      status_word[afe_regmap_pkg::BIT_LEAD_OFF] = flags_q[5];
      status_word[afe_regmap_pkg::BIT_LEADS_ON] = flags_q[4];
      status_word[afe_regmap_pkg::BIT_BEAT] = flags_q[3];
      status_word[afe_regmap_pkg::BIT_SAMPLE] = flags_q[2];
      status_word[afe_regmap_pkg::BIT_CLK_UNLOCK] = flags_q[1];
      status_word[3:0] = detail_q;
   end

   assign sdo_out = sdo_q;
   assign queue_pop_out = pop_q;
   assign beat_cfg_a_out = beat_cfg_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_null_read_zero: assert property (@(posedge sclk_in) disable iff (csn_in)
      (rd_q && (addr_q == afe_regmap_pkg::ADDR_NULL_LOW || addr_q == afe_regmap_pkg::ADDR_NULL_HIGH))
      |=> !sdo_q) else $error("null register read drove a one");
   a_null_write_kept: assert property (@(posedge sclk_in) disable iff (!resetn_in)
      (!csn_in && !rd_q && cnt_q == afe_regmap_pkg::CLEAR_EDGE - 6'h01
       && (addr_q == afe_regmap_pkg::ADDR_NULL_HIGH || addr_q == afe_regmap_pkg::ADDR_NULL_LOW))
      |=> $stable(cal_cfg_q) && $stable(beat_a_q)) else $error("null write changed config");
   a_lead_off_qual: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $rose(flags_q[5]) |-> $past(lo_qual)) else $error("lead-off set without qualification");
   a_detail_with_lo: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $rose(detail_q[0]) |-> flags_q[5]) else $error("detail flag without lead-off");
   a_ovf_holds: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (flags_q[7] && !queue_reset_in && !resync_in) |=> flags_q[7])
      else $error("overflow flag dropped without reset");
   a_clear_status: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (clr_pulse && ev_s[9:5] == 5'h00 && !lo_qual) |=> flags_q[6:1] == 6'h00)
      else $error("status read did not clear flags");
   a_unused_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      status_word[19:12] == 8'h00 && status_word[7:4] == 4'h0) else $error("unused bit set");
   a_single_pop: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      pop_q |=> !pop_q) else $error("pop pulse longer than one cycle");
   c_status_read: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) clr_pulse);
   c_lead_off: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) $rose(flags_q[5]));
   c_pop: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) pop_q);
endmodule : afe_status_regmap

// *** spi_host_model.sv ***
// Behavioural serial host that runs frames on the link of the register bank.
`timescale 1ns/1ps
module spi_host_model (
   // Serial link towards the device.
   output logic sclk_out,
   output logic csn_out,
   output logic sdi_out,
   input wire logic sdo_in
);
   localparam realtime HALF = 6.0;

   initial begin
      sclk_out = 1'b0;
      csn_out = 1'b1;
      sdi_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One frame of a header and whole data words; the clock stands low between frames.
   task automatic xfer(input logic [6:0] addr, input logic rd, input logic [23:0] wdata,
                       input int words, output logic [23:0] rdata);
      int nbits;
      logic [7:0] head;
      nbits = 8 + 24 * words;
      head = {addr, rd};
      rdata = 24'h00_0000;
      #(HALF + 1.7);
      csn_out = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi_out = (i < 8) ? head[7 - i] : wdata[23 - ((i - 8) % 24)];
         #HALF;
         sclk_out = 1'b1;
         #HALF;
         sclk_out = 1'b0;
         if (i >= 8) begin
            rdata = {rdata[22:0], sdo_in};
         end
      end
      #HALF;
      csn_out = 1'b1;
      // The released data line must not keep showing its last level.
      sdi_out = ~sdi_out;
   endtask : xfer
endmodule : spi_host_model

// *** tb.sv ***
// Self-checking testbench for the status and configuration register bank.
`timescale 1ns/1ps
module tb;
   localparam int LO_CNT = 20;
   logic sys_clk_in;
   logic resetn_in;
   logic sclk_in;
   logic csn_in;
   logic sdi_in;
   logic sdo_out;
   afe_regmap_pkg::event_in_s events_in;
   afe_regmap_pkg::electrode_s electrode_in;
   logic lead_off_cond_in;
   logic queue_reset_in;
   logic resync_in;
   logic queue_pop_out;
   logic [23:0] queue_record_in;
   logic [23:0] beat_interval_in;
   logic [23:0] beat_cfg_a_out;
   logic [23:0] rd;
   int num_errors = 0;
   int total_checks = 0;
   int pops = 0;

   afe_status_regmap #(.LEAD_OFF_CNT(LO_CNT)) DUT (.sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in), .sclk_in(sclk_in), .csn_in(csn_in), .sdi_in(sdi_in),
      .sdo_out(sdo_out), .events_in(events_in), .electrode_in(electrode_in),
      .lead_off_cond_in(lead_off_cond_in), .queue_reset_in(queue_reset_in),
      .resync_in(resync_in), .queue_record_in(queue_record_in),
      .beat_interval_in(beat_interval_in), .queue_pop_out(queue_pop_out),
      .beat_cfg_a_out(beat_cfg_a_out));

   spi_host_model host (.sclk_out(sclk_in), .csn_out(csn_in), .sdi_out(sdi_in),
      .sdo_in(sdo_out));

   always @(posedge sys_clk_in) begin
      if (queue_pop_out === 1'b1) begin
         pops <= pops + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic sys_wait(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask : sys_wait

   // A frame, then time for a status clear to cross into the system domain.
   task automatic access(input logic [6:0] a, input logic r, input logic [23:0] w,
                         input int n);
      host.xfer(a, r, w, n, rd);
      sys_wait(8);
   endtask : access

   task automatic wrap_up();
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_config();
      logic [6:0] adr[4] = '{afe_regmap_pkg::ADDR_CAL_CFG, afe_regmap_pkg::ADDR_MUX_CFG,
         afe_regmap_pkg::ADDR_RATE_CFG, afe_regmap_pkg::ADDR_BEAT_CFG_B};
      logic [23:0] msk[4] = '{afe_regmap_pkg::CAL_CFG_MASK, afe_regmap_pkg::MUX_CFG_MASK,
         afe_regmap_pkg::RATE_CFG_MASK, afe_regmap_pkg::BEAT_B_MASK};
      logic [6:0] ign[4] = '{7'h00, 7'h7f, 7'h01, 7'h30};
      for (int i = 0; i < 4; i++) begin
         access(adr[i], 1'b0, 24'hff_ffff, 1);
         access(adr[i], 1'b1, 24'h00_0000, 1);
         check(rd, msk[i]);
      end
      access(afe_regmap_pkg::ADDR_BEAT_CFG_A, 1'b0, 24'hff_ffff, 1);
      check(beat_cfg_a_out, afe_regmap_pkg::BEAT_A_MASK);
      for (int i = 0; i < 4; i++) begin
         access(ign[i], 1'b0, 24'h00_0000, 1);
      end
      for (int i = 0; i < 4; i++) begin
         access(adr[i], 1'b1, 24'h00_0000, 1);
         check(rd, msk[i]);
      end
      check(beat_cfg_a_out, afe_regmap_pkg::BEAT_A_MASK);
      access(afe_regmap_pkg::ADDR_BEAT_CFG_A, 1'b1, 24'h00_0000, 1);
      check(rd, afe_regmap_pkg::BEAT_A_MASK);
   endtask : test_config

   task automatic test_status();
      lead_off_cond_in <= 1'b1;
      electrode_in <= '1;
      sys_wait(LO_CNT / 2);
      lead_off_cond_in <= 1'b0;
      electrode_in <= '0;
      sys_wait(6);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h00_0000);
      events_in <= '1;
      electrode_in <= '1;
      lead_off_cond_in <= 1'b1;
      sys_wait(LO_CNT * 2);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'hf0_0f0f);
      events_in <= '0;
      electrode_in <= '0;
      lead_off_cond_in <= 1'b0;
      sys_wait(6);
      access(afe_regmap_pkg::ADDR_NULL_LOW, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h00_0000);
      access(afe_regmap_pkg::ADDR_NULL_HIGH, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h00_0000);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h70_0f0f);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h40_0000);
      queue_reset_in <= 1'b1;
      sys_wait(1);
      queue_reset_in <= 1'b0;
      sys_wait(4);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h00_0000);
      events_in.queue_overflow_flag <= 1'b1;
      sys_wait(4);
      events_in.queue_overflow_flag <= 1'b0;
      sys_wait(6);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h40_0000);
      resync_in <= 1'b1;
      sys_wait(1);
      resync_in <= 1'b0;
      sys_wait(4);
      access(afe_regmap_pkg::ADDR_STATUS, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h00_0000);
   endtask : test_status

   task automatic test_queue();
      int p0;
      queue_record_in <= 24'h12_3456;
      beat_interval_in <= 24'hab_cdef;
      sys_wait(2);
      p0 = pops;
      access(afe_regmap_pkg::ADDR_QUEUE_SINGLE, 1'b1, 24'h00_0000, 1);
      check(rd, 24'h12_3456);
      check(24'(pops - p0), 24'h00_0001);
      p0 = pops;
      access(afe_regmap_pkg::ADDR_QUEUE_BURST, 1'b1, 24'h00_0000, 2);
      check(rd, 24'h12_3456);
      check(24'(pops - p0), 24'h00_0002);
      access(afe_regmap_pkg::ADDR_BEAT_INTERVAL, 1'b1, 24'h00_0000, 1);
      check(rd, 24'hab_cdef);
   endtask : test_queue

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   initial begin
      resetn_in = 1'b0;
      events_in = '0;
      electrode_in = '0;
      lead_off_cond_in = 1'b0;
      queue_reset_in = 1'b0;
      resync_in = 1'b0;
      queue_record_in = 24'h00_0000;
      beat_interval_in = 24'h00_0000;
      sys_wait(4);
      resetn_in <= 1'b1;
      sys_wait(2);
      test_config();
      test_status();
      test_queue();
      wrap_up();
   end

   // Cuts a hang short well after all frames should have run.
   initial begin
      #200_000;
      num_errors++;
      wrap_up();
   end
endmodule : tb
